/* src/hfosc_ctrl.sv */
// high-frequency oscillator control with AXI4-Lite register slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "hfosc_regs.svh"

module hfosc_ctrl
(
	input  wire logic                     CLK,
	input  wire logic                     RST,
	input  wire logic [11:0]              S_AXI_AWADDR,
	input  wire logic                     S_AXI_AWVALID,
	output logic                          S_AXI_AWREADY,
	input  wire logic [31:0]              S_AXI_WDATA,
	input  wire logic [3:0]               S_AXI_WSTRB,
	input  wire logic                     S_AXI_WVALID,
	output logic                          S_AXI_WREADY,
	output logic [1:0]                    S_AXI_BRESP,
	output logic                          S_AXI_BVALID,
	input  wire logic                     S_AXI_BREADY,
	input  wire logic [11:0]              S_AXI_ARADDR,
	input  wire logic                     S_AXI_ARVALID,
	output logic                          S_AXI_ARREADY,
	output logic [31:0]                   S_AXI_RDATA,
	output logic [1:0]                    S_AXI_RRESP,
	output logic                          S_AXI_RVALID,
	input  wire logic                     S_AXI_RREADY,
	input  wire logic [4:0]               FACTORY_TRIM,
	input  wire logic                     USB_NONIDLE_EVENT,
	input  wire logic                     BUS_POWER_PRESENT,
	input  wire logic                     BUS_POWER_POLARITY_SELECT,
	output logic                          HF_OSC_RUN,
	output logic [4:0]                    PERIOD_TRIM_VALUE,
	output logic                          SYSTEM_CLOCK_EN,
	output hfosc_pkg::hfosc_sys_src_t     SYSTEM_CLOCK_SOURCE,
	output hfosc_pkg::hfosc_usb_src_t     USB_SIDE_CLOCK_SOURCE,
	output logic                          CLOCK_RECOVERY_EN
);
	import hfosc_pkg::*;

	localparam logic [4:0] SETTLE_LAST = 5'(`HFOSC_SETTLE_CYCLES - 1);
	localparam logic [7:0] RST_CONTROL = `HFOSC_RST_CONTROL;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ============================================================
	// registers
	logic             hf_osc_enable_r;
	logic             suspend_req_r;
	logic [1:0]       sys_clock_divider_select_r;
	logic [4:0]       period_trim_value_r;
	hfosc_sys_src_t   sys_src_r;
	hfosc_usb_src_t   usb_src_r;
	logic             recovery_r;
	hfosc_state_t     state_r;
	hfosc_state_t     state_nxt;
	logic [4:0]       settle_cnt_r;
	logic [2:0]       div_cnt_r;
	logic [2:0]       div_last;
	logic             sys_en_r;
	logic [2:0]       usb_sync_r;
	logic [2:0]       vbus_sync_r;
	logic             usb_evt_r;
	logic             vbus_lvl_r;
	logic             wake;
	logic             hf_osc_ready_flag;

	// ============================================================
	// AXI4-Lite slave
	logic             aw_held_r;
	logic [11:0]      aw_addr_r;
	logic             w_held_r;
	logic [31:0]      w_data_r;
	logic [3:0]       w_strb_r;
	logic             bvalid_r;
	logic [1:0]       bresp_r;
	logic             rvalid_r;
	logic [31:0]      rdata_r;
	logic [1:0]       rresp_r;
	logic             wr_fire;
	logic             wr_ctl;
	logic             wr_cal;
	logic             wr_sel;
	logic [7:0]       rd_byte;
	logic             rd_hit;

	assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
	assign S_AXI_WREADY  = !w_held_r && !bvalid_r;
	assign S_AXI_BVALID  = bvalid_r;
	assign S_AXI_BRESP   = bresp_r;
	assign S_AXI_ARREADY = !rvalid_r;
	assign S_AXI_RVALID  = rvalid_r;
	assign S_AXI_RDATA   = rdata_r;
	assign S_AXI_RRESP   = rresp_r;

	assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
	assign wr_ctl  = wr_fire && w_strb_r[0]
		&& aw_addr_r == `HFOSC_ADDR_CONTROL;
	assign wr_cal  = wr_fire && w_strb_r[0]
		&& aw_addr_r == `HFOSC_ADDR_CALIB;
	assign wr_sel  = wr_fire && w_strb_r[0]
		&& aw_addr_r == `HFOSC_ADDR_CLKSEL;

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 12'h0000;
		end
		else if (S_AXI_AWVALID && S_AXI_AWREADY)
		begin
			aw_held_r <= 1'b1;
			aw_addr_r <= {S_AXI_AWADDR[11:2], 2'h0};
		end
		else if (wr_fire)
			aw_held_r <= 1'b0;
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end
		else if (S_AXI_WVALID && S_AXI_WREADY)
		begin
			w_held_r <= 1'b1;
			w_data_r <= S_AXI_WDATA;
			w_strb_r <= S_AXI_WSTRB;
		end
		else if (wr_fire)
			w_held_r <= 1'b0;
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_r <= 1'b1;
			bresp_r  <= (aw_addr_r == `HFOSC_ADDR_CONTROL
				|| aw_addr_r == `HFOSC_ADDR_CALIB
				|| aw_addr_r == `HFOSC_ADDR_CLKSEL) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (S_AXI_BREADY)
			bvalid_r <= 1'b0;
	end

	// read mux
	always_comb
	begin
		rd_byte = 8'h00;
		rd_hit  = 1'b1;
		case ({S_AXI_ARADDR[11:2], 2'h0})
			`HFOSC_ADDR_CONTROL:
				rd_byte = {hf_osc_enable_r, hf_osc_ready_flag,
					suspend_req_r, 3'h0, sys_clock_divider_select_r};
			`HFOSC_ADDR_CALIB:
				rd_byte = recovery_r ? 8'h00
					: {3'h0, period_trim_value_r};
			`HFOSC_ADDR_CLKSEL:
				rd_byte = {recovery_r, 1'b0, usb_src_r, 2'h0, sys_src_r};
			default:
				rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= RESP_OKAY;
		end
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			rvalid_r <= 1'b1;
			rdata_r  <= {24'h00_0000, rd_byte};
			rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (S_AXI_RREADY)
			rvalid_r <= 1'b0;
	end

	// ============================================================
	// control and calibration registers
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			hf_osc_enable_r            <= RST_CONTROL[`HFOSC_BIT_ENABLE];
			sys_clock_divider_select_r <= `HFOSC_RST_DIV;
		end
		else if (wr_ctl)
		begin
			hf_osc_enable_r            <= w_data_r[`HFOSC_BIT_ENABLE];
			sys_clock_divider_select_r <= w_data_r[1:0];
		end
	end

	// set by software wins over a wake in the same cycle
	always_ff @(posedge CLK)
	begin
		if (RST)
			suspend_req_r <= 1'b0;
		else if (wr_ctl && w_data_r[`HFOSC_BIT_SUSPEND])
			suspend_req_r <= 1'b1;
		else if (wake)
			suspend_req_r <= 1'b0;
	end

	// factory value loaded while reset is held
	always_ff @(posedge CLK)
	begin
		if (RST)
			period_trim_value_r <= FACTORY_TRIM;
		else if (wr_cal)
			period_trim_value_r <= w_data_r[4:0];
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			sys_src_r  <= SYS_SRC_HF_OSC;
			usb_src_r  <= USB_SRC_INT;
			recovery_r <= 1'b0;
		end
		else if (wr_sel)
		begin
			sys_src_r  <= hfosc_sys_src_t'(w_data_r[1:0]);
			usb_src_r  <= (w_data_r[5:4] == 2'h3) ? usb_src_r
				: hfosc_usb_src_t'(w_data_r[5:4]);
			recovery_r <= w_data_r[`HFOSC_BIT_RECOVERY];
		end
	end

	// ============================================================
	// wake inputs: three stages, change once stages two and three agree
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			usb_sync_r  <= 3'h0;
			vbus_sync_r <= 3'h0;
		end
		else
		begin
			usb_sync_r  <= {usb_sync_r[1:0], USB_NONIDLE_EVENT};
			vbus_sync_r <= {vbus_sync_r[1:0], BUS_POWER_PRESENT};
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			usb_evt_r  <= 1'b0;
			vbus_lvl_r <= 1'b0;
		end
		else
		begin
			if (usb_sync_r[1] == usb_sync_r[2])
				usb_evt_r <= usb_sync_r[2];
			if (vbus_sync_r[1] == vbus_sync_r[2])
				vbus_lvl_r <= vbus_sync_r[2];
		end
	end

	// transceiver enable deliberately not a term here
	assign wake = usb_evt_r
		|| (vbus_lvl_r == BUS_POWER_POLARITY_SELECT);

	// ============================================================
	// oscillator state
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			OSC_OFF:
				if (hf_osc_enable_r)
					state_nxt = OSC_SETTLE;
			OSC_SUSP:
				if (!hf_osc_enable_r)
					state_nxt = OSC_OFF;
				else if (!suspend_req_r)
					state_nxt = OSC_SETTLE;
			OSC_SETTLE:
				if (!hf_osc_enable_r)
					state_nxt = OSC_OFF;
				else if (suspend_req_r)
					state_nxt = OSC_SUSP;
				else if (settle_cnt_r == SETTLE_LAST)
					state_nxt = OSC_RUN;
			OSC_RUN:
				if (!hf_osc_enable_r)
					state_nxt = OSC_OFF;
				else if (suspend_req_r)
					state_nxt = OSC_SUSP;
			default:
				state_nxt = OSC_OFF;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
			state_r <= OSC_SETTLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge CLK)
	begin
		if (RST || state_r != OSC_SETTLE || wr_cal)
			settle_cnt_r <= 5'h00;
		else if (settle_cnt_r != SETTLE_LAST)
			settle_cnt_r <= settle_cnt_r + 5'h01;
	end

	assign hf_osc_ready_flag = (state_r == OSC_RUN);
	assign HF_OSC_RUN        = (state_r == OSC_RUN) || (state_r == OSC_SETTLE);
	assign PERIOD_TRIM_VALUE = period_trim_value_r;
	assign SYSTEM_CLOCK_SOURCE   = sys_src_r;
	assign USB_SIDE_CLOCK_SOURCE = usb_src_r;
	assign CLOCK_RECOVERY_EN     = recovery_r;

	// ============================================================
	// system clock divider: one pulse every 8, 4, 2 or 1 cycles
	always_comb
	begin
		case (sys_clock_divider_select_r)
			2'h0:    div_last = 3'h7;
			2'h1:    div_last = 3'h3;
			2'h2:    div_last = 3'h1;
			default: div_last = 3'h0;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (RST || !HF_OSC_RUN || div_cnt_r >= div_last)
			div_cnt_r <= 3'h0;
		else
			div_cnt_r <= div_cnt_r + 3'h1;
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
			sys_en_r <= 1'b0;
		else
			sys_en_r <= HF_OSC_RUN && div_cnt_r >= div_last;
	end

	assign SYSTEM_CLOCK_EN = sys_en_r;

	// ============================================================
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	int unsigned gap_r;
	always_ff @(posedge CLK)
	begin
		if (RST || sys_en_r)
			gap_r <= 0;
		else
			gap_r <= gap_r + 1;
	end

	// cycles since the divider setting or run state last moved
	logic [4:0] steady_r;
	always_ff @(posedge CLK)
	begin
		if (RST || !HF_OSC_RUN || wr_ctl)
			steady_r <= 5'h00;
		else if (steady_r != 5'h1f)
			steady_r <= steady_r + 5'h01;
	end

	chk_reset_sel_hf: assert property ($rose(!RST) |-> sys_src_r == SYS_SRC_HF_OSC && sys_clock_divider_select_r == 2'h0) else $error("reset source or divider wrong");
	chk_div8_spacing: assert property (sys_clock_divider_select_r == 2'h0 && sys_en_r && steady_r >= 5'h10 |-> gap_r == 7) else $error("divide by 8 spacing wrong");
	chk_div1_each: assert property (sys_clock_divider_select_r == 2'h3 && HF_OSC_RUN && $past(HF_OSC_RUN) |=> sys_en_r) else $error("divide by 1 missed a pulse");
	chk_suspend_stop: assert property (wr_ctl && w_data_r[5] && state_r == OSC_RUN |=> ##1 state_r == OSC_SUSP) else $error("suspend did not stop oscillator");
	chk_wake_restart: assert property (state_r == OSC_SUSP && hf_osc_enable_r && wake && !wr_ctl |-> ##[1:2] state_r == OSC_SETTLE) else $error("wake did not restart");
	chk_enable_off: assert property (!hf_osc_enable_r |-> ##1 !HF_OSC_RUN) else $error("disabled oscillator still runs");
	chk_ready_flag: assert property (!hf_osc_enable_r || suspend_req_r |=> !hf_osc_ready_flag) else $error("ready while stopped");
	chk_trim_write: assert property (wr_cal |=> period_trim_value_r == $past(w_data_r[4:0])) else $error("trim write lost");
	chk_trim_hidden: assert property (recovery_r && rvalid_r && $past(S_AXI_ARADDR) == `HFOSC_ADDR_CALIB && $rose(rvalid_r) |-> rdata_r == 32'h0000_0000) else $error("trim visible under recovery");
	chk_unused_zero: assert property ($rose(rvalid_r) && $past(S_AXI_ARADDR) == `HFOSC_ADDR_CONTROL |-> rdata_r[4:2] == 3'h0) else $error("unused bits not zero");
	chk_settle_len: assert property ($rose(state_r == OSC_SETTLE) && hf_osc_enable_r |-> !hf_osc_ready_flag [*5]) else $error("ready came too early");

	cov_suspend_wake: cover property (state_r == OSC_SUSP ##[1:50] state_r == OSC_RUN);
	cov_div_change:   cover property (wr_ctl ##[1:20] sys_en_r);
	cov_unmapped:     cover property (bvalid_r && bresp_r == RESP_SLVERR);

endmodule
`default_nettype wire

/* src/hfosc_regs.svh */
// register map, field positions, reset values and timing counts
// Operation
// - after reset the high-frequency oscillator is the system clock source
// - after reset the system clock divider selects divide by 8
// - divider code 00 divides by 8, 01 by 4, 10 by 2, 11 by 1
// - writing one to control bit 5 stops the oscillator
// - suspended oscillator restarts on USB activity or matching bus power
// - USB wake detection works even while the transceiver is disabled
// - control bit 7 enables the oscillator; it resets to one
// - 5-bit trim in bits 4..0: zero fastest, all ones slowest
// - trim resets to a part-specific factory value giving 12 MHz
// - trim read back is undefined while USB clock recovery is enabled
// - system clock source: HF osc, LF osc, external, multiplier over 2
// - USB clock source: internal osc, external osc or 4x multiplier
`ifndef HFOSC_REGS_SVH
`define HFOSC_REGS_SVH

// ============================================================
// register indices and byte addresses
`define HFOSC_IDX_CONTROL     8'hb2
`define HFOSC_IDX_CALIB       8'hb3
`define HFOSC_IDX_CLKSEL      8'hb4
`define HFOSC_ADDR_CONTROL    12'h02c8
`define HFOSC_ADDR_CALIB      12'h02cc
`define HFOSC_ADDR_CLKSEL     12'h02d0

// ============================================================
// fields
`define HFOSC_BIT_ENABLE      7
`define HFOSC_BIT_READY       6
`define HFOSC_BIT_SUSPEND     5
`define HFOSC_BIT_RECOVERY    7
`define HFOSC_RST_CONTROL     8'h80
`define HFOSC_RST_DIV         2'h0
`define HFOSC_RST_SYSSRC      2'h0
`define HFOSC_RST_USBSRC      2'h0

// ============================================================
// timing
`define HFOSC_CLK_PERIOD_NS   25
`define HFOSC_SETTLE_NS       400
`define HFOSC_SETTLE_CYCLES   \
	((`HFOSC_SETTLE_NS + `HFOSC_CLK_PERIOD_NS - 1) / `HFOSC_CLK_PERIOD_NS)

`endif

/* src/hfosc_pkg.sv */
// types of the high-frequency oscillator control block
package hfosc_pkg;

	typedef enum logic [3:0]
	{
		OSC_OFF    = 4'h1,
		OSC_SUSP   = 4'h2,
		OSC_SETTLE = 4'h4,
		OSC_RUN    = 4'h8
	} hfosc_state_t;

	typedef enum logic [1:0]
	{
		SYS_SRC_HF_OSC = 2'h0,
		SYS_SRC_LF_OSC = 2'h1,
		SYS_SRC_EXT    = 2'h2,
		SYS_SRC_MUL_2  = 2'h3
	} hfosc_sys_src_t;

	typedef enum logic [1:0]
	{
		USB_SRC_INT = 2'h0,
		USB_SRC_EXT = 2'h1,
		USB_SRC_MUL = 2'h2
	} hfosc_usb_src_t;

endpackage

/* test/hfosc_far_model.sv */
// far-side model: system clock consumer and USB wake source
`timescale 1ns/10ps
`default_nettype none

module hfosc_far_model
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       usb_kick,
	input  wire logic       pwr_req,
	input  wire logic       sys_clk_en,
	output logic            usb_event,
	output var logic        bus_power,
	output var logic [3:0]  gap
);
	logic [2:0] ev_r;
	logic [3:0] cnt_r;

	// ============================================================
	// wake sources
	// resume signalling held a few cycles, transceiver left off
	always_ff @(posedge clk)
	begin
		if (rst)
			ev_r <= 3'h0;
		else if (usb_kick)
			ev_r <= 3'h7;
		else if (ev_r != 3'h0)
			ev_r <= ev_r - 3'h1;
	end
	assign usb_event = (ev_r != 3'h0);

	always_ff @(posedge clk)
	begin
		if (rst)
			bus_power <= 1'b0;
		else
			bus_power <= pwr_req;
	end

	// ============================================================
	// spacing of system clock enables
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_r <= 4'h0;
			gap <= 4'h0;
		end
		else if (sys_clk_en)
		begin
			gap <= cnt_r + 4'h1;
			cnt_r <= 4'h0;
		end
		else if (cnt_r != 4'hf)
			cnt_r <= cnt_r + 4'h1;
	end
endmodule
`default_nettype wire

/* test/testbench.sv */
// testbench of the high-frequency oscillator control block
`timescale 1ns/10ps
`default_nettype none
`include "hfosc_regs.svh"

module testbench;
	import hfosc_pkg::*;
	logic           clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic [11:0]    awaddr, araddr;
	logic [31:0]    wdata, r_data;
	logic [3:0]     wstrb, gap;
	logic           aw_rdy, w_rdy, b_vld, ar_rdy, r_vld;
	logic [1:0]     b_resp, r_resp;
	logic           usb_ev, bus_pwr, osc_run, sys_en, rec_en;
	logic           usb_kick, pwr_req, vb_pol;
	logic [4:0]     trim;
	hfosc_sys_src_t sys_src;
	hfosc_usb_src_t usb_src;
	int             fail_count, total_checks;

	hfosc_ctrl dut_u
	(
		.CLK(clk), .RST(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(aw_rdy),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_vld),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(ar_rdy),
		.S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_vld),
		.S_AXI_RREADY(rready), .FACTORY_TRIM(5'h0d),
		.USB_NONIDLE_EVENT(usb_ev), .BUS_POWER_PRESENT(bus_pwr),
		.BUS_POWER_POLARITY_SELECT(vb_pol), .HF_OSC_RUN(osc_run),
		.PERIOD_TRIM_VALUE(trim), .SYSTEM_CLOCK_EN(sys_en),
		.SYSTEM_CLOCK_SOURCE(sys_src), .USB_SIDE_CLOCK_SOURCE(usb_src),
		.CLOCK_RECOVERY_EN(rec_en)
	);

	hfosc_far_model far_u
	(
		.clk(clk), .rst(rst), .usb_kick(usb_kick), .pwr_req(pwr_req),
		.sys_clk_en(sys_en), .usb_event(usb_ev), .bus_power(bus_pwr),
		.gap(gap)
	);

	// ============================================================
	// reporting
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task hang(input string what);
		fail_count++;
		$display("[ERR] %s expected done seen timeout", what);
		give_verdict();
	endtask

	// ============================================================
	// bus and wait tasks
	task axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
		bit done;
		done = 0;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h00_0000, d};
		wstrb <= 4'h1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		repeat (50)
		begin
			@(posedge clk);
			if (aw_rdy === 1'b1)
				awvalid <= 1'b0;
			if (w_rdy === 1'b1)
				wvalid <= 1'b0;
			if (b_vld === 1'b1)
			begin
				bready <= 1'b0;
				chk("write response", e, b_resp);
				done = 1;
				break;
			end
		end
		if (!done)
			hang("write");
	endtask

	task axi_rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
		bit done;
		done = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		repeat (50)
		begin
			@(posedge clk);
			if (ar_rdy === 1'b1)
				arvalid <= 1'b0;
			if (r_vld === 1'b1)
			begin
				rready <= 1'b0;
				chk("read data", {24'h00_0000, d}, r_data);
				chk("read response", e, r_resp);
				done = 1;
				break;
			end
		end
		if (!done)
			hang("read");
	endtask

	task wait_run(input logic lvl, input int bound);
		bit done;
		done = 0;
		repeat (bound)
		begin
			@(posedge clk);
			if (osc_run === lvl)
			begin
				done = 1;
				break;
			end
		end
		if (!done)
			hang("oscillator run");
		else
			chk("oscillator run", lvl, osc_run);
	endtask

	// ============================================================
	// clock, watchdog and scenarios
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		hang("run");
	end

	initial
	begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, usb_kick, pwr_req} = '0;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		vb_pol = 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		axi_rd(`HFOSC_ADDR_CONTROL, 8'h80, 2'h0);
		chk("system source", SYS_SRC_HF_OSC, sys_src);
		axi_rd(`HFOSC_ADDR_CALIB, 8'h0d, 2'h0);
		repeat (20) @(posedge clk);
		axi_rd(`HFOSC_ADDR_CONTROL, 8'hc0, 2'h0);
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			axi_wr(`HFOSC_ADDR_CONTROL, 8'h9c | 8'(i), 2'h0);
			repeat (40) @(posedge clk);
			chk("divider gap", 32'h0000_0008 >> i, gap);
			axi_rd(`HFOSC_ADDR_CONTROL, 8'hc0 | 8'(i), 2'h0);
		end
		$display("test divider done");
		for (int i = 0; i < 3; i++)
		begin
			axi_wr(`HFOSC_ADDR_CALIB, 8'(32'h0000_1f15 >> (i * 4)), 2'h0);
			chk("trim out", 5'h1f & 5'(32'h0000_1f15 >> (i * 4)), trim);
		end
		axi_rd(`HFOSC_ADDR_CALIB, 8'h1f, 2'h0);
		$display("test trim done");
		for (int i = 0; i < 4; i++)
		begin
			axi_wr(`HFOSC_ADDR_CLKSEL, 8'((i % 3) * 16 + i), 2'h0);
			chk("system source", i, sys_src);
			chk("usb source", i % 3, usb_src);
		end
		axi_wr(`HFOSC_ADDR_CLKSEL, 8'h80, 2'h0);
		chk("recovery", 1'b1, rec_en);
		axi_rd(`HFOSC_ADDR_CALIB, 8'h00, 2'h0);
		axi_wr(`HFOSC_ADDR_CLKSEL, 8'h00, 2'h0);
		axi_rd(`HFOSC_ADDR_CALIB, 8'h1f, 2'h0);
		$display("test sources done");
		axi_wr(`HFOSC_ADDR_CONTROL, 8'h00, 2'h0);
		wait_run(1'b0, 10);
		axi_rd(`HFOSC_ADDR_CONTROL, 8'h00, 2'h0);
		axi_wr(`HFOSC_ADDR_CONTROL, 8'h80, 2'h0);
		wait_run(1'b1, 10);
		repeat (20) @(posedge clk);
		$display("test enable done");
		axi_wr(`HFOSC_ADDR_CONTROL, 8'ha0, 2'h0);
		wait_run(1'b0, 10);
		axi_rd(`HFOSC_ADDR_CONTROL, 8'ha0, 2'h0);
		usb_kick <= 1'b1;
		@(posedge clk);
		usb_kick <= 1'b0;
		wait_run(1'b1, 40);
		repeat (20) @(posedge clk);
		axi_rd(`HFOSC_ADDR_CONTROL, 8'hc0, 2'h0);
		axi_wr(`HFOSC_ADDR_CONTROL, 8'ha0, 2'h0);
		wait_run(1'b0, 10);
		repeat (20) @(posedge clk);
		chk("still stopped", 1'b0, osc_run);
		pwr_req <= 1'b1;
		wait_run(1'b1, 40);
		// low polarity: bus power present no longer wakes, its loss does
		vb_pol <= 1'b0;
		axi_wr(`HFOSC_ADDR_CONTROL, 8'ha0, 2'h0);
		wait_run(1'b0, 10);
		repeat (20) @(posedge clk);
		chk("stopped at low polarity", 1'b0, osc_run);
		pwr_req <= 1'b0;
		wait_run(1'b1, 40);
		$display("test suspend done");
		axi_wr(12'h000, 8'h55, 2'h2);
		axi_rd(12'h000, 8'h00, 2'h2);
		$display("test unmapped done");
		give_verdict();
	end
endmodule
`default_nettype wire
